//--- hcpfs_top.sv
// What this block does
// - Strap picks pin A: parallel bit or strobe.
// - Pin A function fixed at the first clock edge after reset release.
// - Strap picks pin B: parallel bit or ident.
// - Pin B function fixed at the first clock edge after reset release.
// - Parallel bit A starts as input.
// - Address strobe is input only, never driven.
// - Strobe captures bus byte into address register.
// - Strobe ignored outside multiplexed mode.
// - Parallel bit B starts as input.
// - Host cycle is two bytes on bus.
`timescale 1ns/1ps
`default_nettype none

module hcpfs_top
  import hcpfs_pkg::*;
#(
  parameter int unsigned BUS_W = HCPFS_BUS_W
) (
  input  wire logic               MCLK,
  input  wire logic               RSTN,
  input  wire logic               BOOT_SELECT_STRAP,
  input  wire logic               HOST_CTRL_PIN_A_IN,
  output logic                    HOST_CTRL_PIN_A_OUT,
  output logic                    HOST_CTRL_PIN_A_OE,
  input  wire logic               HOST_CTRL_PIN_B_IN,
  output logic                    HOST_CTRL_PIN_B_OUT,
  output logic                    HOST_CTRL_PIN_B_OE,
  input  wire logic               PARALLEL_IO_BIT_A_DATA,
  input  wire logic               PARALLEL_IO_BIT_A_DIR_OUT,
  input  wire logic               PARALLEL_IO_BIT_B_DATA,
  input  wire logic               PARALLEL_IO_BIT_B_DIR_OUT,
  output logic                    PARALLEL_IO_BIT_A_VAL,
  output logic                    PARALLEL_IO_BIT_B_VAL,
  input  wire logic               HOST_MUX_MODE,
  input  wire logic [BUS_W-1:0]   HOST_DATA_IN,
  output logic                    HOST_ADDR_STROBE_N,
  output logic                    HOST_BYTE_IDENT,
  output logic [2*BUS_W-1:0]      HOST_ADDR_REG,
  output logic                    HOST_ADDR_LATCHED,
  output logic                    FUNC_VALID,
  output logic                    FUNC_HOST
);

  // The state record is built on the package widths; other widths would need
  // a wider address register and are refused here.
  if (BUS_W != HCPFS_BUS_W) begin : g_bad_width
    $error("hcpfs_top supports only the documented bus width");
  end

  typedef struct packed {
    logic                    pa_out;
    logic                    pa_oe;
    logic                    pb_out;
    logic                    pb_oe;
    logic                    pio_a_val;
    logic                    pio_b_val;
    logic                    strobe_n;
    logic                    ident;
    logic [2*BUS_W-1:0]      addr;
    logic                    latched;
    logic                    valid;
    logic                    host;
  } hcpfs_state_t;

  localparam hcpfs_state_t HCPFS_ST_RST = '{
    pa_out:    HCPFS_DO_RST,
    pa_oe:     HCPFS_OE_RST,
    pb_out:    HCPFS_DO_RST,
    pb_oe:     HCPFS_OE_RST,
    pio_a_val: HCPFS_PIO_RST,
    pio_b_val: HCPFS_PIO_RST,
    strobe_n:  HCPFS_STROBE_IDLE,
    ident:     HCPFS_IDENT_IDLE,
    addr:      HCPFS_ADDR_RST,
    latched:   HCPFS_LATCH_RST,
    valid:     1'h0,
    host:      1'h0
  };

  hcpfs_func_t  func;
  hcpfs_state_t st_r;
  hcpfs_state_t st_nxt;
  logic         sel_pio;
  logic         sel_host;
  logic         strobe_fall;

  //////////////////////////////////////////////////////////////////////////////

  hcpfs_strap_latch u_strap_latch (
    .clk   (MCLK),
    .rst_n (RSTN),
    .strap (BOOT_SELECT_STRAP),
    .func  (func)
  );

  assign sel_pio  = (func == HCPFS_FN_PARALLEL_IO);
  assign sel_host = (func == HCPFS_FN_HOST_PORT);

  // Edge seen against the registered strobe, so one low pulse gives one
  // capture however long the host holds it.
  assign strobe_fall = sel_host && HOST_MUX_MODE && st_r.strobe_n && !HOST_CTRL_PIN_A_IN;

  always_comb begin
    st_nxt         = st_r;
    st_nxt.valid   = (func != HCPFS_FN_UNSET);
    st_nxt.host    = sel_host;
    // Until the strap is decided both pins stay undriven, so neither function
    // can fight the board during the first edge after reset.
    st_nxt.pa_oe   = sel_pio && PARALLEL_IO_BIT_A_DIR_OUT;
    st_nxt.pb_oe   = sel_pio && PARALLEL_IO_BIT_B_DIR_OUT;
    st_nxt.pa_out  = sel_pio ? PARALLEL_IO_BIT_A_DATA : HCPFS_DO_RST;
    st_nxt.pb_out  = sel_pio ? PARALLEL_IO_BIT_B_DATA : HCPFS_DO_RST;
    st_nxt.pio_a_val = sel_pio ? HOST_CTRL_PIN_A_IN : HCPFS_PIO_RST;
    st_nxt.pio_b_val = sel_pio ? HOST_CTRL_PIN_B_IN : HCPFS_PIO_RST;
    st_nxt.strobe_n  = sel_host ? HOST_CTRL_PIN_A_IN : HCPFS_STROBE_IDLE;
    st_nxt.ident     = sel_host ? HOST_CTRL_PIN_B_IN : HCPFS_IDENT_IDLE;
    st_nxt.latched   = 1'h0;
    if (strobe_fall) begin
      st_nxt.latched = 1'h1;
      // The host's byte identification tells which half of the cycle this is.
      if (HOST_CTRL_PIN_B_IN == HCPFS_IDENT_FIRST) begin
        st_nxt.addr[2*BUS_W-1:BUS_W] = HOST_DATA_IN;
      end else begin
        st_nxt.addr[BUS_W-1:0] = HOST_DATA_IN;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      st_r <= HCPFS_ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign HOST_CTRL_PIN_A_OUT   = st_r.pa_out;
  assign HOST_CTRL_PIN_A_OE    = st_r.pa_oe;
  assign HOST_CTRL_PIN_B_OUT   = st_r.pb_out;
  assign HOST_CTRL_PIN_B_OE    = st_r.pb_oe;
  assign PARALLEL_IO_BIT_A_VAL = st_r.pio_a_val;
  assign PARALLEL_IO_BIT_B_VAL = st_r.pio_b_val;
  assign HOST_ADDR_STROBE_N    = st_r.strobe_n;
  assign HOST_BYTE_IDENT       = st_r.ident;
  assign HOST_ADDR_REG         = st_r.addr;
  assign HOST_ADDR_LATCHED     = st_r.latched;
  assign FUNC_VALID            = st_r.valid;
  assign FUNC_HOST             = st_r.host;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  // A drive request taken at the second edge after release may turn the pin
  // round from then on, so only a drive that nobody asked for is an error.
  AST_PIO_A_INPUT_AT_START: assert property (
    !FUNC_VALID |-> !HOST_CTRL_PIN_A_OE ##1 (!HOST_CTRL_PIN_A_OE || $past(PARALLEL_IO_BIT_A_DIR_OUT))
  ) else $error("pin A driven before the parallel function was enabled");

  AST_PIO_B_INPUT_AT_START: assert property (
    !FUNC_VALID |-> !HOST_CTRL_PIN_B_OE ##1 (!HOST_CTRL_PIN_B_OE || $past(PARALLEL_IO_BIT_B_DIR_OUT))
  ) else $error("pin B driven before the parallel function was enabled");

  AST_HOST_NEVER_DRIVES: assert property (
    FUNC_HOST |-> !HOST_CTRL_PIN_A_OE && !HOST_CTRL_PIN_B_OE
  ) else $error("control pin driven while host functions are selected");

  AST_ROUTE_A: assert property (
    sel_host |=> HOST_ADDR_STROBE_N == $past(HOST_CTRL_PIN_A_IN) && PARALLEL_IO_BIT_A_VAL == HCPFS_PIO_RST
  ) else $error("pin A not routed to the address strobe");

  AST_ROUTE_B: assert property (
    sel_pio |=> PARALLEL_IO_BIT_B_VAL == $past(HOST_CTRL_PIN_B_IN) && HOST_BYTE_IDENT == HCPFS_IDENT_IDLE
  ) else $error("pin B not routed to the parallel bit");

  AST_SELECTION_KEPT: assert property (
    FUNC_VALID |=> FUNC_VALID && $stable(FUNC_HOST)
  ) else $error("selected function changed after reset release");

  AST_CAPTURE_FIRST: assert property (
    strobe_fall && HOST_CTRL_PIN_B_IN == HCPFS_IDENT_FIRST
      |=> HOST_ADDR_LATCHED && HOST_ADDR_REG[2*BUS_W-1:BUS_W] == $past(HOST_DATA_IN)
  ) else $error("first address byte not captured on strobe");

  AST_CAPTURE_SECOND: assert property (
    strobe_fall && HOST_CTRL_PIN_B_IN != HCPFS_IDENT_FIRST
      |=> HOST_ADDR_LATCHED && HOST_ADDR_REG[BUS_W-1:0] == $past(HOST_DATA_IN)
        && $stable(HOST_ADDR_REG[2*BUS_W-1:BUS_W])
  ) else $error("second address byte not captured on strobe");

  AST_NO_MUX_IGNORED: assert property (
    !HOST_MUX_MODE |=> !HOST_ADDR_LATCHED && $stable(HOST_ADDR_REG)
  ) else $error("strobe honoured outside multiplexed mode");

  AST_PIO_QUIET_HOST: assert property (
    sel_pio |=> HOST_ADDR_STROBE_N == HCPFS_STROBE_IDLE && HOST_BYTE_IDENT == HCPFS_IDENT_IDLE
      && !HOST_ADDR_LATCHED
  ) else $error("host inputs active while parallel function selected");

  COV_HOST_TWO_BYTES: cover property (
    strobe_fall && HOST_CTRL_PIN_B_IN == HCPFS_IDENT_FIRST ##[1:20]
    strobe_fall && HOST_CTRL_PIN_B_IN != HCPFS_IDENT_FIRST
  );

  COV_PIO_DRIVES_A: cover property (
    sel_pio && PARALLEL_IO_BIT_A_DIR_OUT ##1 HOST_CTRL_PIN_A_OE
  );

  COV_STROBE_NO_MUX: cover property (
    sel_host && !HOST_MUX_MODE && st_r.strobe_n && !HOST_CTRL_PIN_A_IN
  );

endmodule : hcpfs_top

`default_nettype wire

//--- hcpfs_pkg.sv
`default_nettype none

package hcpfs_pkg;

  // Width of the shared host address/data bus.
  localparam int unsigned HCPFS_BUS_W = 8;
  // The host address register holds one byte from each half of a host cycle.
  localparam int unsigned HCPFS_ADDR_W = 2 * HCPFS_BUS_W;

  // Strap level that selects the host port functions.
  localparam logic HCPFS_STRAP_HOST  = 1'h1;
  // Idle level of the active-low address strobe.
  localparam logic HCPFS_STROBE_IDLE = 1'h1;
  // Byte-identification level that marks the first byte of a host cycle.
  localparam logic HCPFS_IDENT_FIRST = 1'h0;
  // Level shown on the internal byte identification while it is unused.
  localparam logic HCPFS_IDENT_IDLE  = 1'h0;

  // Values after reset.
  localparam logic                    HCPFS_OE_RST   = 1'h0;
  localparam logic                    HCPFS_DO_RST   = 1'h0;
  localparam logic                    HCPFS_PIO_RST  = 1'h0;
  localparam logic                    HCPFS_LATCH_RST = 1'h0;
  localparam logic [HCPFS_ADDR_W-1:0] HCPFS_ADDR_RST = 16'h0000;

  typedef enum logic [1:0] {
    HCPFS_FN_UNSET,
    HCPFS_FN_PARALLEL_IO,
    HCPFS_FN_HOST_PORT
  } hcpfs_func_t;

endpackage : hcpfs_pkg

`default_nettype wire

//--- hcpfs_strap_latch.sv
`timescale 1ns/1ps
`default_nettype none

module hcpfs_strap_latch
  import hcpfs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        strap,
  output var  hcpfs_func_t func
);

  typedef struct packed {
    hcpfs_func_t func;
  } hcpfs_latch_st_t;

  hcpfs_latch_st_t st_r;
  hcpfs_latch_st_t st_nxt;

  // The strap is caught by the first edge after reset release, never by the
  // asynchronous reset itself, so the board must hold it through that edge.
  always_comb begin
    st_nxt = st_r;
    case (st_r.func)
      HCPFS_FN_UNSET: begin
        st_nxt.func = (strap == HCPFS_STRAP_HOST) ? HCPFS_FN_HOST_PORT : HCPFS_FN_PARALLEL_IO;
      end
      HCPFS_FN_PARALLEL_IO,
      HCPFS_FN_HOST_PORT: begin
        st_nxt.func = st_r.func;
      end
      default: begin
        st_nxt.func = HCPFS_FN_UNSET;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{func: HCPFS_FN_UNSET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign func = st_r.func;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_LATCH_DECIDES: assert property (
    func == HCPFS_FN_UNSET |=> func != HCPFS_FN_UNSET
  ) else $error("function not decided one edge after reset release");

  AST_LATCH_HOLDS: assert property (
    func != HCPFS_FN_UNSET |=> $stable(func) [*4]
  ) else $error("function selection changed after it was fixed");

  AST_LATCH_FOLLOWS_STRAP: assert property (
    func == HCPFS_FN_UNSET |=> (func == HCPFS_FN_HOST_PORT) == ($past(strap) == HCPFS_STRAP_HOST)
  ) else $error("function does not match the strap level");

endmodule : hcpfs_strap_latch

`default_nettype wire

//--- hcpfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module hcpfs_host_model
  import hcpfs_pkg::*;
(
  input  wire logic              clk,
  output logic                   pin_a,
  output logic                   pin_b,
  output logic [HCPFS_BUS_W-1:0] data
);
  initial begin
    pin_a = HCPFS_STROBE_IDLE;
    pin_b = HCPFS_IDENT_FIRST;
    data  = 8'h00;
  end

  task automatic drive(input logic a, input logic b);
    @(posedge clk);
    #1;
    pin_a = a;
    pin_b = b;
  endtask : drive

  ////////////////////////////////////////////////////////////////
  // Released data shows its inverse, so a stale byte never passes for a fresh one.
  task automatic xfer(input logic ident, input logic [HCPFS_BUS_W-1:0] byte_v);
    @(posedge clk);
    #1;
    pin_b = ident;
    data  = byte_v;
    pin_a = 1'h0;
    @(posedge clk);
    #1;
    pin_a = HCPFS_STROBE_IDLE;
    data  = ~data;
    @(posedge clk);
  endtask : xfer

  task automatic cycle(input logic [2*HCPFS_BUS_W-1:0] addr);
    xfer(HCPFS_IDENT_FIRST, addr[15:8]);
    xfer(~HCPFS_IDENT_FIRST, addr[7:0]);
  endtask : cycle
endmodule : hcpfs_host_model

`default_nettype wire

//--- tb_hcpfs_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_hcpfs_top
  import hcpfs_pkg::*;
;
  logic        mclk, rstn, strap, mux;
  logic        a_out, a_oe, b_out, b_oe, val_a, val_b;
  logic        da, dra, db, drb, strobe_n, ident, latched, fvalid, fhost;
  logic [15:0] addr_reg;
  logic        host_a, host_b;
  logic [7:0]  hdata;
  wire         pin_a = a_oe ? a_out : host_a;
  wire         pin_b = b_oe ? b_out : host_b;
  int          err_count, num_checks, lat_cnt;

  hcpfs_top hcpfs_top_i (.MCLK(mclk), .RSTN(rstn), .BOOT_SELECT_STRAP(strap),
    .HOST_CTRL_PIN_A_IN(pin_a), .HOST_CTRL_PIN_A_OUT(a_out), .HOST_CTRL_PIN_A_OE(a_oe),
    .HOST_CTRL_PIN_B_IN(pin_b), .HOST_CTRL_PIN_B_OUT(b_out), .HOST_CTRL_PIN_B_OE(b_oe),
    .PARALLEL_IO_BIT_A_DATA(da), .PARALLEL_IO_BIT_A_DIR_OUT(dra),
    .PARALLEL_IO_BIT_B_DATA(db), .PARALLEL_IO_BIT_B_DIR_OUT(drb),
    .PARALLEL_IO_BIT_A_VAL(val_a), .PARALLEL_IO_BIT_B_VAL(val_b),
    .HOST_MUX_MODE(mux), .HOST_DATA_IN(hdata), .HOST_ADDR_STROBE_N(strobe_n),
    .HOST_BYTE_IDENT(ident), .HOST_ADDR_REG(addr_reg), .HOST_ADDR_LATCHED(latched),
    .FUNC_VALID(fvalid), .FUNC_HOST(fhost));

  hcpfs_host_model host_i (.clk(mclk), .pin_a(host_a), .pin_b(host_b), .data(hdata));

  always #10 mclk = ~mclk;

  always @(posedge mclk) begin
    if (latched === 1'h1) begin
      lat_cnt++;
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  task automatic wait_lat(input int n);
    for (int i = 0; i < 8 && lat_cnt < n; i++) @(posedge mclk);
    if (lat_cnt < n) begin
      err_count++;
      $display("BAD %0t latch timeout", $time);
      report_and_stop;
    end else begin
      #1;
    end
  endtask : wait_lat

  task automatic do_reset(input logic s);
    rstn  = 1'h0;
    strap = s;
    settle;
    rstn  = 1'h1;
    settle;
    chk(fvalid, 1'h1, "valid");
    chk(fhost, s, "host");
    chk(a_oe, 1'h0, "oe a");
    chk(b_oe, 1'h0, "oe b");
  endtask : do_reset

  ////////////////////////////////////////////////////////////////
  task automatic t_parallel;
    do_reset(1'h0);
    mux = 1'h1;
    host_i.drive(1'h0, 1'h1);
    settle;
    chk(val_a, 1'h0, "val a");
    chk(val_b, 1'h1, "val b");
    chk(strobe_n, 1'h1, "strobe");
    chk(ident, 1'h0, "ident");
    lat_cnt = 0;
    host_i.cycle(16'h5aa5);
    settle;
    chk(16'(lat_cnt), 16'h0, "no latch");
    dra = 1'h1;
    da  = 1'h1;
    drb = 1'h1;
    db  = 1'h1;
    settle;
    chk(a_oe, 1'h1, "drive a");
    chk(a_out, 1'h1, "out a");
    chk(val_a, 1'h1, "val a high");
    chk(b_oe, 1'h1, "drive b");
    chk(b_out, 1'h1, "out b");
    {dra, drb, db} = 3'h0;
    strap = 1'h1;
    settle;
    chk(fhost, 1'h0, "late strap");
  endtask : t_parallel

  task automatic t_host;
    do_reset(1'h1);
    chk(ident, 1'h1, "ident host");
    chk(val_b, 1'h0, "val b host");
    dra = 1'h1;
    drb = 1'h1;
    settle;
    chk(a_oe, 1'h0, "strobe oe");
    chk(b_oe, 1'h0, "ident oe");
    dra     = 1'h0;
    drb     = 1'h0;
    lat_cnt = 0;
    host_i.cycle(16'h1234);
    wait_lat(2);
    chk(addr_reg, 16'h1234, "addr");
    mux = 1'h0;
    host_i.xfer(1'h0, 8'hff);
    settle;
    chk(16'(lat_cnt), 16'h2, "mux off");
    chk(addr_reg, 16'h1234, "addr kept");
    host_i.drive(1'h0, 1'h1);
    settle;
    chk(strobe_n, 1'h0, "strobe low");
    chk(16'(lat_cnt), 16'h2, "low no mux");
    host_i.drive(1'h1, 1'h1);
  endtask : t_host

  initial begin
    mclk = 1'h0;
    rstn = 1'h0;
    strap = 1'h0;
    mux = 1'h0;
    {da, dra, db, drb} = 4'h0;
    t_parallel;
    t_host;
    report_and_stop;
  end
endmodule : tb_hcpfs_top

`default_nettype wire
